// ### dv/host_model.sv
// Host side model that drives the control octet handshake
`timescale 1ns/1ps
module host_model
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Command request from bench
  input  wire logic       go,
  // Octet toward the lamp block
  output logic      [7:0] host_control_octet
);
  // One handshake flip per command, so each command differs from the one before
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      host_control_octet <= 8'h00;
    else if (go)
      host_control_octet <= host_control_octet ^ 8'h01;
endmodule : host_model

// ### dv/testbench.sv
// Self-checking bench for the diagnostic lamp block
`timescale 1ns/1ps
module testbench;
  import diag_lamp_pkg::*;
  localparam int BL = 8;
  localparam int MI = 20;
  logic mclk = 0, rst_b = 0, read = 0, write = 0, go = 0, rnd = 0;
  logic a1b = 0, a1w = 0, a2b = 0, a2w = 0, term_char = 0, f;
  logic txs = 0, txl = 0, rxf = 0, rxd = 0, pd = 0, fb = 0;
  logic e1, e2, etx, erx, pr = 0, pm = 0;
  logic [7:0]  address = 8'h00;
  logic [7:0]  po;
  logic [31:0] writedata = 32'h0, q;
  wire  [31:0] readdata;
  wire  [7:0]  oct;
  wire         waitrequest, l1, l2, run_lamp, tx_lamp, rx_lamp, mon;
  int          err_total = 0, compares = 0, cnt = 0, ok = 0, n;
  diag_lamp #(.BLINK_CYCLES(BL), .MON_IDLE_CYCLES(MI)) DUT
  (
    .mclk(mclk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .ant1_busy(a1b), .ant1_auto_wait(a1w),
    .ant2_busy(a2b), .ant2_auto_wait(a2w), .term_char(term_char),
    .tx_queue_start(txs), .tx_last_handed(txl), .rx_cmd_fetched(rxf),
    .rx_msg_done(rxd), .host_control_octet(oct), .parse_done(pd),
    .antenna_one_lamp(l1), .antenna_two_lamp(l2), .run_lamp(run_lamp),
    .tx_lamp(tx_lamp), .rx_lamp(rx_lamp), .monitor_active(mon)
  );
  host_model host
    (.mclk(mclk), .rst_b(rst_b), .go(go), .host_control_octet(oct));
  always #5 mclk = ~mclk;
  task automatic chk(input string s, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // Avalon master: hold until waitrequest low, bounded wait
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    write <= 0;
    read <= 0;
    if (k >= 50)
    begin
      err_total++;
      close_out();
    end
    @(posedge mclk);
  endtask : bus
  task automatic run(input int c);
    rnd <= 1;
    repeat (c) @(posedge mclk);
    rnd <= 0;
    repeat (4) @(posedge mclk);
  endtask : run
  // Quiet phase clears tx and rx; parse_done kept off a fresh change
  always @(posedge mclk)
  begin
    {a1b, a1w, a2b, a2w} <= rnd ? 4'($urandom) : {a1b, a1w, a2b, a2w};
    txs <= rnd && $urandom_range(4) == 0;
    txl <= !rnd || $urandom_range(4) == 0;
    f = rnd && $urandom_range(4) == 0;
    rxf <= !fb && f;
    rxd <= !fb && (!rnd || (!f && $urandom_range(4) == 0));
    go <= rnd && $urandom_range(5) == 0;
    pd <= fb && !go && (!rnd || $urandom_range(5) == 0);
  end
  // Reference model of the lamps
  always @(posedge mclk)
    if (!rst_b)
      {e1, e2, etx, erx, po} = {4'h0, oct};
    else
    begin
      e1 = a1b | a1w;
      e2 = a2b | a2w;
      etx = txs ? 1'b1 : (txl ? 1'b0 : etx);
      if (!fb)
        erx = rxf ? 1'b1 : (rxd ? 1'b0 : erx);
      else if (!erx && oct !== po)
        erx = 1;
      else if (pd)
        erx = 0;
      po = oct;
    end
  always @(negedge mclk)
    if (rst_b)
    begin
      chk("ant1", e1, l1);
      chk("ant2", e2, l2);
      chk("tx", etx, tx_lamp);
      chk("rx", erx, rx_lamp);
      if (mon && pm)
        chk("frozen", pr, run_lamp);
      if (mon)
        ok = 0;
      if (run_lamp !== pr)
      begin
        if (ok)
          chk("blink", BL, cnt);
        ok = !mon;
        cnt = 0;
      end
      cnt++;
      pr = run_lamp;
      pm = mon;
    end
  initial
  begin
    void'($urandom(32637));
    repeat (20) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    bus(0, 8'h00, 0);
    chk("ctrl", 0, q);
    bus(1, 8'h08, 32'h5A);
    bus(0, 8'h08, 0);
    chk("station", 0, q);
    bus(1, 8'h00, 32'h4);
    bus(1, 8'h08, 32'h5A);
    bus(0, 8'h08, 0);
    chk("station", 32'h5A, q);
    bus(0, 8'h10, 0);
    chk("unmapped", 0, q);
    for (int m = 0; m < 2; m++)
    begin
      bus(1, 8'h00, 32'h4 | m);
      fb <= m[0];
      run(400);
      bus(0, 8'h04, 0);
      chk("status", {26'h0, 2'b0, etx, 1'b0, e2, e1}, q & 32'h3B);
      bus(0, 8'h0C, 0);
      chk("octet", {24'h0, oct}, q);
    end
    bus(1, 8'h00, 32'h6);
    fb <= 0;
    bus(0, 8'h00, 0);
    chk("ctrl", 32'h4, q);
    for (int i = 0; i < 60; i++)
    begin
      term_char <= (i % 10 == 0);
      @(posedge mclk);
    end
    chk("monitor", 1, mon);
    n = 0;
    while (mon === 1'b1 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    chk("idle exit", 1, n >= MI - 12 && n <= MI - 5);
    run(200);
    close_out();
  end
endmodule : testbench

// ### include/diag_lamp_map.svh
// Offsets, fields, reset values and timing counts of the lamp block
`ifndef DIAG_LAMP_MAP_SVH
`define DIAG_LAMP_MAP_SVH
// Sized unsigned so the thirty second product cannot overflow
`define CLK_HZ          32'h05F5E100
`define BLINK_MS        500
`define BLINK_CYC       (`CLK_HZ / 1000 * `BLINK_MS)
`define MON_IDLE_S      30
`define MON_IDLE_CYC    (`CLK_HZ * `MON_IDLE_S)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_STATION     8'h08
`define REG_OCTET       8'h0C
`define CTRL_FIELDBUS   0
`define CTRL_MON_ENTER  1
`define CTRL_FB_FITTED  2
`define CTRL_RESET      32'h00000000
`define STATION_RESET   8'h00
`endif

// ### include/diag_lamp_pkg.sv
// Types of the diagnostic lamp block
package diag_lamp_pkg;
  typedef enum logic [1:0]
  {
    rx_idle  = 2'b00,
    rx_fetch = 2'b01,
    rx_parse = 2'b10
  } rx_state_e;
  typedef logic [7:0] octet_t;
endpackage : diag_lamp_pkg

// ### logic/diag_lamp.sv
// Diagnostic lamp driver with Avalon-MM register slave
`timescale 1ns/1ps
`include "diag_lamp_map.svh"
module diag_lamp
  import diag_lamp_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = `BLINK_CYC,
  parameter int unsigned MON_IDLE_CYCLES = `MON_IDLE_CYC
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Antenna activity
  input  wire logic        ant1_busy,
  input  wire logic        ant1_auto_wait,
  input  wire logic        ant2_busy,
  input  wire logic        ant2_auto_wait,
  // Terminal monitor
  input  wire logic        term_char,
  // Host transmit path
  input  wire logic        tx_queue_start,
  input  wire logic        tx_last_handed,
  // Host receive path
  input  wire logic        rx_cmd_fetched,
  input  wire logic        rx_msg_done,
  input  wire logic [7:0]  host_control_octet,
  input  wire logic        parse_done,
  // Lamps
  output logic             antenna_one_lamp,
  output logic             antenna_two_lamp,
  output logic             run_lamp,
  output logic             tx_lamp,
  output logic             rx_lamp,
  output logic             monitor_active
);

  logic [31:0] ctrl;
  octet_t      station;
  octet_t      octet_prev;
  logic [31:0] blink_cnt;
  logic [31:0] idle_cnt;
  logic        ack;
  rx_state_e   rx_state;
  logic        fieldbus;
  logic        octet_chg;
  logic        next_ack;

  function automatic logic cnt_done(input logic [31:0] c,
                                    input int unsigned lim);
    cnt_done = (c >= lim - 1);
  endfunction : cnt_done

  assign fieldbus  = ctrl[`CTRL_FIELDBUS];
  assign octet_chg = host_control_octet != octet_prev;

  // One wait cycle per access keeps readdata registered
  assign next_ack = (read || write) && !ack;

  // Waitrequest kept as a flop, always the inverse of ack
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack         <= 1'b0;
      waitrequest <= 1'b1;
    end
    else
    begin
      ack         <= next_ack;
      waitrequest <= !next_ack;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl    <= `CTRL_RESET;
      station <= `STATION_RESET;
    end
    else if (write && ack)
    begin
      if (address == `REG_CTRL)
        ctrl <= {29'h0, writedata[2:0]};
      if (address == `REG_STATION && ctrl[`CTRL_FB_FITTED])
        station <= writedata[7:0];
    end
    else
      ctrl[`CTRL_MON_ENTER] <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      readdata <= 32'h00000000;
    else if (read && !ack)
      unique case (address)
        `REG_CTRL:    readdata <= ctrl;
        `REG_STATUS:  readdata <= {26'h0, monitor_active, rx_lamp,
                                   tx_lamp, run_lamp, antenna_two_lamp,
                                   antenna_one_lamp};
        `REG_STATION: readdata <= {24'h0, station};
        `REG_OCTET:   readdata <= {24'h0, octet_prev};
        default:      readdata <= 32'h00000000;
      endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      antenna_one_lamp <= 1'b0;
      antenna_two_lamp <= 1'b0;
    end
    else
    begin
      antenna_one_lamp <= ant1_busy || ant1_auto_wait;
      antenna_two_lamp <= ant2_busy || ant2_auto_wait;
    end
  end

  // Monitor entry by software; leaves on terminal silence
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      monitor_active <= 1'b0;
      idle_cnt       <= 32'h00000000;
    end
    else if (ctrl[`CTRL_MON_ENTER])
    begin
      monitor_active <= 1'b1;
      idle_cnt       <= 32'h00000000;
    end
    else if (monitor_active)
    begin
      if (term_char)
        idle_cnt <= 32'h00000000;
      else if (cnt_done(idle_cnt, MON_IDLE_CYCLES))
      begin
        monitor_active <= 1'b0;
        idle_cnt       <= 32'h00000000;
      end
      else
        idle_cnt <= idle_cnt + 32'h00000001;
    end
  end

  // Prescaler runs on in monitor, only the lamp freezes
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blink_cnt <= 32'h00000000;
      run_lamp  <= 1'b0;
    end
    else if (cnt_done(blink_cnt, BLINK_CYCLES))
    begin
      blink_cnt <= 32'h00000000;
      if (!monitor_active)
        run_lamp <= !run_lamp;
    end
    else
      blink_cnt <= blink_cnt + 32'h00000001;
  end

  // Start wins over end when both arrive together
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      tx_lamp <= 1'b0;
    else if (tx_queue_start)
      tx_lamp <= 1'b1;
    else if (tx_last_handed)
      tx_lamp <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      octet_prev <= 8'h00;
    else
      octet_prev <= host_control_octet;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_state <= rx_idle;
      rx_lamp  <= 1'b0;
    end
    else
      unique case (rx_state)
        rx_idle:
          if (fieldbus && octet_chg)
          begin
            rx_state <= rx_parse;
            rx_lamp  <= 1'b1;
          end
          else if (!fieldbus && rx_cmd_fetched)
          begin
            rx_state <= rx_fetch;
            rx_lamp  <= 1'b1;
          end
        rx_fetch:
          if (rx_msg_done)
          begin
            rx_state <= rx_idle;
            rx_lamp  <= 1'b0;
          end
        rx_parse:
          if (parse_done)
          begin
            rx_state <= rx_idle;
            rx_lamp  <= 1'b0;
          end
        default:
        begin
          rx_state <= rx_idle;
          rx_lamp  <= 1'b0;
        end
      endcase
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  ant_one_a: assert property (##1 antenna_one_lamp ==
    $past(ant1_busy || ant1_auto_wait)) else $error("lamp one wrong");
  ant_two_a: assert property (##1 antenna_two_lamp ==
    $past(ant2_busy || ant2_auto_wait)) else $error("lamp two wrong");
  run_blink_a: assert property ((!monitor_active &&
    cnt_done(blink_cnt, BLINK_CYCLES)) |=> run_lamp != $past(run_lamp))
    else $error("run lamp missed toggle");
  run_freeze_a: assert property (monitor_active |=> $stable(run_lamp))
    else $error("run lamp moved in monitor");
  mon_exit_a: assert property ((monitor_active && !term_char &&
    !ctrl[`CTRL_MON_ENTER] && cnt_done(idle_cnt, MON_IDLE_CYCLES))
    |=> !monitor_active) else $error("monitor did not exit");
  tx_on_a: assert property (tx_queue_start |=> tx_lamp)
    else $error("tx lamp not on");
  tx_off_a: assert property ((tx_last_handed && !tx_queue_start)
    |=> !tx_lamp) else $error("tx lamp not off");
  rx_on_a: assert property ((rx_state == rx_idle && !fieldbus &&
    rx_cmd_fetched) |=> rx_lamp ##0 rx_state == rx_fetch)
    else $error("rx lamp not on");
  rx_fb_a: assert property ((rx_state == rx_idle && fieldbus &&
    octet_chg) |=> rx_lamp) else $error("rx lamp missed octet change");
  rx_fb_off_a: assert property ((rx_state == rx_parse && parse_done)
    |=> !rx_lamp) else $error("rx lamp not off after parse");
  bus_ack_a: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("bus ack late");

  // Hold, gating and octet copy checks, plus the rx_fetch exit and monitor entry transitions
  station_lock_a: assert property ((write && ack &&
    !ctrl[`CTRL_FB_FITTED]) |=> $stable(station))
    else $error("station written while module absent");
  bus_idle_a: assert property ((!read && !write) |=> waitrequest)
    else $error("waitrequest low without request");
  rx_off_a: assert property ((rx_state == rx_fetch && rx_msg_done)
    |=> !rx_lamp) else $error("rx lamp not off after message");
  rx_mode_a: assert property ((rx_state == rx_idle && !fieldbus &&
    !rx_cmd_fetched) |=> !rx_lamp)
    else $error("rx lamp lit in serial idle");
  rx_hold_a: assert property ((rx_state == rx_parse && !parse_done)
    |=> rx_lamp) else $error("rx lamp dropped before parse end");
  octet_track_a: assert property (##1 octet_prev ==
    $past(host_control_octet)) else $error("octet copy stale");
  mon_enter_a: assert property (ctrl[`CTRL_MON_ENTER]
    |=> monitor_active) else $error("monitor not entered");
  mon_stay_a: assert property ((monitor_active && term_char)
    |=> monitor_active) else $error("monitor left despite input");
  run_hold_a: assert property (!cnt_done(blink_cnt, BLINK_CYCLES)
    |=> $stable(run_lamp)) else $error("run lamp toggled off tick");
  tx_hold_a: assert property ((!tx_queue_start && !tx_last_handed)
    |=> $stable(tx_lamp)) else $error("tx lamp moved unprompted");

  tx_cycle_c: cover property (tx_queue_start ##[1:20] tx_last_handed);
  fb_cmd_c: cover property (rx_state == rx_parse ##[1:20] parse_done);
  mon_c: cover property (monitor_active ##1 !monitor_active);
  station_c: cover property (write && ack && address == `REG_STATION);
  rx_cmd_c: cover property (rx_state == rx_fetch ##[1:20] rx_msg_done);

endmodule : diag_lamp
